// ==== design/xlate_unit.sv ====
/*
  data-side translation unit: two-level translation buffers, table pointer,
  fault capture, cache unit control and partial-store watchpoint.
  assumes synchronous inputs and privileged software driving the write ports.
*/
`timescale 1ns/100ps
module xlate_unit #(
  parameter int FA_WAYS = 8,
  parameter int SA_SETS = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic lu_valid,
  input wire logic [xlate_pkg::VA_W-1:0] lu_va,
  output logic lu_hit,
  output logic [xlate_pkg::PA_W-1:0] lu_pa,
  output logic [xlate_pkg::VA_W-1:0] table_ptr,
  input wire logic di_valid,
  input wire xlate_pkg::translation_entry_s di_entry,
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic [xlate_pkg::VA_W-1:0] acc_addr,
  input wire xlate_pkg::translation_entry_s acc_wdata,
  output xlate_pkg::translation_entry_s acc_rdata,
  output logic acc_ack,
  input wire logic tbr_wr,
  input wire logic [xlate_pkg::VA_W-1:0] tbr_wdata,
  output logic [xlate_pkg::VA_W-1:0] tbr_rdata,
  input wire logic cucr_wr,
  input wire logic [xlate_pkg::VA_W-1:0] cucr_wdata,
  output logic [xlate_pkg::VA_W-1:0] cucr_rdata,
  output logic spec_access_en,
  input wire logic address_mask_bit,
  input wire logic fault_valid,
  input wire logic fault_indirect_jump,
  input wire logic fault_misaligned,
  input wire logic [xlate_pkg::VA_W-1:0] fault_va,
  input wire logic [xlate_pkg::FSR_W-1:0] fault_status,
  output logic [xlate_pkg::VA_W-1:0] data_fault_address_reg,
  output logic [xlate_pkg::FSR_W-1:0] data_fault_status_reg,
  input wire logic ps_valid,
  input wire logic [xlate_pkg::VA_W-1:0] ps_va,
  input wire logic [xlate_pkg::VA_W-1:0] watch_va,
  output logic watch_trap
);
  import xlate_pkg::*;
  localparam int FA_IW = $clog2(FA_WAYS);
  localparam int SET_W = $clog2(SA_SETS);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta;
  logic rst_sync_b;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync_b <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [VTAG_W-1:0] keep_mask(input logic [SIZE_W-1:0] sz);
    logic [VTAG_W-1:0] m;
    m = '1;
    m = m << (PAGE_STEP * int'(sz));
    return m;
  endfunction : keep_mask

  // a call result cannot be part-selected, so the narrow mask has its own helper
  function automatic logic [PPN_W-1:0] ppn_keep(input logic [SIZE_W-1:0] sz);
    logic [VTAG_W-1:0] m;
    m = keep_mask(sz);
    return m[PPN_W-1:0];
  endfunction : ppn_keep

  function automatic logic entry_match(input translation_entry_s e,
                                       input logic [VA_W-1:0] va);
    return e.valid && (((e.vtag ^ va[VA_W-1:PAGE_LSB]) & keep_mask(e.size)) == '0);
  endfunction : entry_match

  function automatic translation_entry_s clean_entry(input translation_entry_s e);
    translation_entry_s c;
    c = e;
    c.ppn = e.ppn & ppn_keep(e.size);
    return c;
  endfunction : clean_entry

  // ----------------------------------------------------------------
  // buffers and lookup
  // ----------------------------------------------------------------
  translation_entry_s fa [FA_WAYS];
  translation_entry_s sa [SA_SETS][2];
  logic sa_lru [SA_SETS];
  logic [FA_WAYS-1:0] fa_hit_vec;
  logic [FA_WAYS-1:0] fa_valid_vec;
  logic [FA_WAYS-1:0] fa_lock_vec;
  logic [1:0] sa_hit_vec;
  logic [SET_W-1:0] lu_set;
  logic [FA_IW-1:0] fa_hit_idx;
  translation_entry_s hit_e;
  logic any_hit;

  assign lu_set = lu_va[PAGE_LSB +: SET_W];

  for (genvar i = 0; i < FA_WAYS; i++) begin : g_fa
    assign fa_hit_vec[i] = entry_match(fa[i], lu_va);
    assign fa_valid_vec[i] = fa[i].valid;
    assign fa_lock_vec[i] = fa[i].lock && fa[i].valid;
  end
  for (genvar w = 0; w < 2; w++) begin : g_sa
    assign sa_hit_vec[w] = entry_match(sa[lu_set][w], lu_va);
  end

  always_comb begin
    fa_hit_idx = '0;
    for (int i = FA_WAYS - 1; i >= 0; i--) begin
      if (fa_hit_vec[i]) fa_hit_idx = FA_IW'(i);
    end
    any_hit = lu_valid && ((|fa_hit_vec) || (|sa_hit_vec));
    hit_e = sa_hit_vec[0] ? sa[lu_set][0] : sa[lu_set][1];
    if (|fa_hit_vec) hit_e = fa[fa_hit_idx];
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      lu_hit <= 1'b0;
      lu_pa <= '0;
    end else begin
      lu_hit <= any_hit;
      if (any_hit) begin
        lu_pa <= {(hit_e.ppn & ppn_keep(hit_e.size)) |
                  (lu_va[PA_W-1:PAGE_LSB] & ~ppn_keep(hit_e.size)),
                  lu_va[PAGE_LSB-1:0]};
      end
    end
  end

  // ----------------------------------------------------------------
  // data-in placement
  // ----------------------------------------------------------------
  translation_entry_s di_clean;
  translation_entry_s fa_new;
  logic di_to_fa;
  logic [SET_W-1:0] di_set;
  logic sa_way;
  logic spill;
  logic fa_alloc;
  logic [FA_IW-1:0] fa_victim;
  logic fa_victim_ok;

  always_comb begin
    di_clean = clean_entry(di_entry);
    di_to_fa = di_entry.lock || (di_entry.size != SZ_8K);
    di_set = di_entry.vtag[SET_W-1:0];
    sa_way = sa_lru[di_set];
    if (!sa[di_set][0].valid) sa_way = 1'b0;
    else if (!sa[di_set][1].valid) sa_way = 1'b1;
    spill = di_valid && !di_to_fa && sa[di_set][sa_way].valid;
    fa_new = di_to_fa ? di_clean : sa[di_set][sa_way];
    fa_alloc = (di_valid && di_to_fa) || spill;
  end

  plru_ways #(.WAYS(FA_WAYS), .IW(FA_IW)) u_plru (
    .clk(clk),
    .rst_sync_b(rst_sync_b),
    .touch(lu_valid && (|fa_hit_vec)),
    .touch_way(fa_hit_idx),
    .alloc(fa_alloc && fa_victim_ok),
    .alloc_way(fa_victim),
    .valid_vec(fa_valid_vec),
    .lock_vec(fa_lock_vec),
    .victim(fa_victim),
    .victim_ok(fa_victim_ok)
  );

  // ----------------------------------------------------------------
  // access-space decode
  // ----------------------------------------------------------------
  logic [ACC_ALIAS_BIT-1:0] acc_off;
  logic acc_sa;
  logic [ACC_IDX_W-1:0] acc_idx;
  logic [FA_IW-1:0] acc_fa;
  logic [SET_W-1:0] acc_set;
  logic acc_way;

  // bits above the alias bit are dropped, so 40000 folds onto 00000
  assign acc_off = acc_addr[ACC_ALIAS_BIT-1:0];
  assign acc_sa = acc_off[ACC_SA_BIT];
  assign acc_idx = acc_off[ACC_IDX_LSB +: ACC_IDX_W];
  assign acc_fa = acc_idx[FA_IW-1:0];
  assign acc_way = acc_idx[0];
  assign acc_set = acc_idx[SET_W:1];

  // ----------------------------------------------------------------
  // buffer storage; access-space writes land last and win a collision
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      for (int i = 0; i < FA_WAYS; i++) fa[i] <= '0;
    end else begin
      if (fa_alloc && fa_victim_ok) begin
        fa[fa_victim] <= fa_new;
      end
      if (acc_valid && acc_write && !acc_sa) fa[acc_fa] <= clean_entry(acc_wdata);
    end
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      for (int s = 0; s < SA_SETS; s++) begin
        sa[s][0] <= '0;
        sa[s][1] <= '0;
      end
    end else begin
      if (di_valid && !di_to_fa) sa[di_set][sa_way] <= di_clean;
      if (acc_valid && acc_write && acc_sa) begin
        sa[acc_set][acc_way] <= clean_entry(acc_wdata);
        sa[acc_set][acc_way].lock <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      for (int s = 0; s < SA_SETS; s++) sa_lru[s] <= 1'b0;
    end else begin
      if (lu_valid && (|sa_hit_vec)) sa_lru[lu_set] <= ~sa_hit_vec[1];
      if (di_valid && !di_to_fa) sa_lru[di_set] <= ~sa_way;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      acc_ack <= 1'b0;
      acc_rdata <= '0;
    end else begin
      acc_ack <= acc_valid;
      if (acc_valid && !acc_write) begin
        acc_rdata <= acc_sa ? sa[acc_set][acc_way] : fa[acc_fa];
        if (acc_sa) acc_rdata.lock <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // table base register and pointer
  // ----------------------------------------------------------------
  logic [TBR_SIZE_W-1:0] tbl_size;
  logic [VA_W-1:TBR_BASE_LSB] tbl_base;
  logic [TBL_IDX_W-1:0] tbl_mask;

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      tbl_size <= '0;
      tbl_base <= '0;
    end else if (tbr_wr) begin
      // hash bits between size and base are not stored
      tbl_size <= tbr_wdata[TBR_SIZE_LSB +: TBR_SIZE_W];
      tbl_base <= tbr_wdata[VA_W-1:TBR_BASE_LSB];
    end
  end

  assign tbr_rdata = {tbl_base, {(TBR_BASE_LSB - TBR_SIZE_W){1'b0}}, tbl_size};
  assign tbl_mask = ~(TBL_IDX_W'({TBL_IDX_W{1'b1}}) << (TBL_MIN_LOG + int'(tbl_size)));

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) table_ptr <= '0;
    else if (lu_valid) begin
      table_ptr <= {tbl_base, {TBR_BASE_LSB{1'b0}}} +
                   VA_W'({lu_va[PAGE_LSB +: TBL_IDX_W] & tbl_mask, {TBL_ENTRY_LSB{1'b0}}});
    end
  end

  // ----------------------------------------------------------------
  // cache unit control: only the speculation gate and watch mask exist
  // ----------------------------------------------------------------
  logic [WMASK_W-1:0] watch_mask;
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      spec_access_en <= CUCR_SPEC_RST;
      watch_mask <= CUCR_WMASK_RST;
    end else if (cucr_wr) begin
      spec_access_en <= cucr_wdata[CUCR_SPEC_BIT];
      watch_mask <= cucr_wdata[CUCR_WMASK_LSB +: WMASK_W];
    end
  end

  always_comb begin
    cucr_rdata = '0;
    cucr_rdata[CUCR_SPEC_BIT] = spec_access_en;
    cucr_rdata[CUCR_WMASK_LSB +: WMASK_W] = watch_mask;
  end

  // the store byte mask is never looked at, so traps are conservative
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) watch_trap <= 1'b0;
    else watch_trap <= ps_valid && (watch_mask != '0) &&
                       (ps_va[VA_W-1:WORD_LSB] == watch_va[VA_W-1:WORD_LSB]);
  end

  // ----------------------------------------------------------------
  // fault capture
  // ----------------------------------------------------------------
  logic fault_take;
  assign fault_take = fault_valid && !(fault_indirect_jump && fault_misaligned);

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      data_fault_address_reg <= '0;
      data_fault_status_reg <= '0;
    end else if (fault_take) begin
      data_fault_status_reg <= fault_status;
      data_fault_address_reg <= fault_va;
      if (address_mask_bit) data_fault_address_reg[VA_W-1:HALF_W] <= '0;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_b);

  AST_SPEC_GATE: assert property (cucr_wr |=> spec_access_en == $past(cucr_wdata[CUCR_SPEC_BIT]))
    else $error("speculation gate does not follow control write");
  AST_CUCR_ZERO: assert property (cucr_wr |=> (cucr_rdata & ~$past(cucr_wdata)) == '0 && cucr_rdata[7:0] == 8'h00)
    else $error("unimplemented control bits read nonzero");
  AST_TBR_SIZE: assert property (tbr_wr |=> tbr_rdata[3:0] == $past(tbr_wdata[3:0]) && tbr_rdata[12:4] == 9'h000)
    else $error("table size or hash field wrong");
  AST_FAULT_HOLD: assert property (fault_valid && fault_indirect_jump && fault_misaligned |=> $stable(data_fault_address_reg) && $stable(data_fault_status_reg))
    else $error("fault registers changed on indirect jump misalign");
  AST_FAULT_AM: assert property (fault_take && address_mask_bit |=> data_fault_address_reg[63:32] == 32'h0 && data_fault_address_reg[31:0] == $past(fault_va[31:0]))
    else $error("masked fault address not truncated");
  AST_WATCH: assert property (ps_valid && watch_mask == '0 |=> !watch_trap)
    else $error("watch trap with zero watch mask");
  AST_WATCH_FIRE: assert property (ps_valid && watch_mask != '0 && ps_va[63:3] == watch_va[63:3] |=> watch_trap)
    else $error("watch trap missed");
  AST_SA_LOCK: assert property (acc_valid && !acc_write && acc_sa |=> acc_ack && !acc_rdata.lock)
    else $error("set-assoc lock bit read as one");
  AST_LOCK_PLACE: assert property (di_valid && di_entry.lock && fa_victim_ok && !(acc_valid && acc_write) |=> $countones(fa_lock_vec) == $past($countones(fa_lock_vec)) + 1)
    else $error("locked entry not placed in full-assoc buffer");
  AST_PA_OFFSET: assert property (any_hit |=> lu_hit && lu_pa[12:0] == $past(lu_va[12:0]))
    else $error("page offset not carried into physical address");

  COV_SPILL: cover property (spill && fa_victim_ok);
  COV_FA_HIT: cover property (lu_valid && (|fa_hit_vec));
  COV_WATCH: cover property (watch_trap);
  COV_FAULT_HOLD: cover property (fault_valid && fault_indirect_jump && fault_misaligned);
endmodule : xlate_unit

// ==== inc/xlate_pkg.sv ====
/*
  shared constants and entry layout for the translation unit.
  assumes one 64-bit virtual address space and a 47-bit physical space.
*/
package xlate_pkg;
  // ----------------------------------------------------------------
  // address widths
  // ----------------------------------------------------------------
  localparam int VA_W = 64;
  localparam int PA_W = 47;
  localparam int PAGE_LSB = 13;
  localparam int VTAG_W = VA_W - PAGE_LSB;
  localparam int PPN_W = PA_W - PAGE_LSB;
  localparam int SIZE_W = 2;
  localparam int PAGE_STEP = 3;
  localparam int HALF_W = 32;
  localparam logic [SIZE_W-1:0] SZ_8K = 2'h0;

  // ----------------------------------------------------------------
  // table base register layout
  // ----------------------------------------------------------------
  localparam int TBR_SIZE_LSB = 0;
  localparam int TBR_SIZE_W = 4;
  localparam int TBR_BASE_LSB = 13;
  localparam int TBL_MIN_LOG = 9;
  localparam int TBL_IDX_W = TBL_MIN_LOG + 15;
  localparam int TBL_ENTRY_LSB = 4;

  // ----------------------------------------------------------------
  // cache unit control register layout
  // ----------------------------------------------------------------
  localparam int CUCR_SPEC_BIT = 41;
  localparam int CUCR_WMASK_LSB = 32;
  localparam int WMASK_W = 8;
  localparam logic CUCR_SPEC_RST = 1'b0;
  localparam logic [WMASK_W-1:0] CUCR_WMASK_RST = 8'h00;
  localparam int WORD_LSB = 3;

  // ----------------------------------------------------------------
  // translation-buffer access space decode
  // ----------------------------------------------------------------
  localparam int ACC_ALIAS_BIT = 18;
  localparam int ACC_SA_BIT = 17;
  localparam int ACC_IDX_LSB = 3;
  localparam int ACC_IDX_W = 8;

  localparam int FSR_W = 16;

  typedef struct packed {
    logic valid;
    logic lock;
    logic [SIZE_W-1:0] size;
    logic [VTAG_W-1:0] vtag;
    logic [PPN_W-1:0] ppn;
  } translation_entry_s;
endpackage : xlate_pkg

// ==== design/plru_ways.sv ====
/*
  bit-per-way pseudo-lru picker for the fully associative buffer.
  assumes touch and alloc indexes are in range; locked ways never chosen.
*/
`timescale 1ns/100ps
module plru_ways #(
  parameter int WAYS = 8,
  parameter int IW = $clog2(WAYS)
) (
  input wire logic clk,
  input wire logic rst_sync_b,
  input wire logic touch,
  input wire logic [IW-1:0] touch_way,
  input wire logic alloc,
  input wire logic [IW-1:0] alloc_way,
  input wire logic [WAYS-1:0] valid_vec,
  input wire logic [WAYS-1:0] lock_vec,
  output logic [IW-1:0] victim,
  output logic victim_ok
);
  logic [WAYS-1:0] used;
  logic [WAYS-1:0] next_used;

  always_comb begin
    next_used = used;
    if (touch) next_used[touch_way] = 1'b1;
    if (alloc) next_used[alloc_way] = 1'b1;
    // once every unlocked way is marked, keep only the fresh ones so history survives
    if (&(next_used | lock_vec)) begin
      next_used = '0;
      if (touch) next_used[touch_way] = 1'b1;
      if (alloc) next_used[alloc_way] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) used <= '0;
    else used <= next_used;
  end

  // free way first, then an unmarked unlocked way, then any unlocked way
  always_comb begin
    victim = '0;
    victim_ok = 1'b0;
    for (int i = WAYS - 1; i >= 0; i--) begin
      if (!lock_vec[i]) begin
        victim = IW'(i);
        victim_ok = 1'b1;
      end
    end
    for (int i = WAYS - 1; i >= 0; i--) begin
      if (!lock_vec[i] && !used[i]) victim = IW'(i);
    end
    for (int i = WAYS - 1; i >= 0; i--) begin
      if (!valid_vec[i]) begin
        victim = IW'(i);
        victim_ok = 1'b1;
      end
    end
  end
endmodule : plru_ways

// ==== tb/pipe_model.sv ====
/*
  pipeline-side partner of the translation unit: issues lookups, returns answers.
  assumes the unit registers its lookup answer on the edge that takes the request.
*/
`timescale 1ns/100ps
module pipe_model (
  input wire logic clk,
  output logic lu_valid,
  output logic [xlate_pkg::VA_W-1:0] lu_va,
  input wire logic lu_hit,
  input wire logic [xlate_pkg::PA_W-1:0] lu_pa
);
  import xlate_pkg::*;
  initial begin
    lu_valid = 1'b0;
    lu_va = '0;
  end
  // address is scrambled once released so the unit cannot lean on a stale bus
  task automatic lookup(input logic [VA_W-1:0] va, output logic hit,
      output logic [PA_W-1:0] pa);
    @(negedge clk);
    lu_valid = 1'b1;
    lu_va = va;
    @(negedge clk);
    lu_valid = 1'b0;
    lu_va = ~va;
    hit = lu_hit;
    pa = lu_pa;
  endtask : lookup
endmodule : pipe_model

// ==== tb/test_xlate_unit.sv ====
/*
  self-checking bench for the translation unit, driving at the falling edge.
  assumes answers are registered on the edge that takes each request.
*/
`timescale 1ns/100ps
module test_xlate_unit;
  import xlate_pkg::*;
  logic clk, rst_b, lu_valid, lu_hit, di_valid, acc_valid, acc_write, acc_ack, tbr_wr, cucr_wr;
  logic spec_access_en, address_mask_bit, fault_valid, fault_indirect_jump, fault_misaligned;
  logic ps_valid, watch_trap, hit;
  logic [VA_W-1:0] lu_va, table_ptr, acc_addr, tbr_wdata, tbr_rdata, cucr_wdata, cucr_rdata;
  logic [VA_W-1:0] fault_va, data_fault_address_reg, ps_va, watch_va;
  logic [PA_W-1:0] lu_pa, pa;
  logic [FSR_W-1:0] fault_status, data_fault_status_reg;
  translation_entry_s di_entry, acc_wdata, acc_rdata, w0, w1;
  int errors, num_checks;
  logic [63:0] base, a, b, c, d;
  logic [23:0] m;

  xlate_unit #(.FA_WAYS(8), .SA_SETS(16)) uut (.*);
  pipe_model u_pipe (.*);

  // ----------------------------------------------------------------
  // clock, compare and closing
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_ent(input translation_entry_s got, input translation_entry_s exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_ent
  task automatic test_done;
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    test_done();
  end

  // ----------------------------------------------------------------
  // access tasks: request up at one falling edge, down at the next
  // ----------------------------------------------------------------
  function automatic translation_entry_s mk(input logic lk, input logic [1:0] sz,
      input logic [63:0] va, input logic [46:0] p);
    mk = '{valid: 1'b1, lock: lk, size: sz, vtag: va[VA_W-1:PAGE_LSB], ppn: p[PA_W-1:PAGE_LSB]};
  endfunction : mk
  task automatic di_wr(input translation_entry_s e);
    @(negedge clk);
    di_valid = 1'b1;
    di_entry = e;
    @(negedge clk);
    di_valid = 1'b0;
  endtask : di_wr
  task automatic acc(input logic wr, input logic [63:0] ad, input translation_entry_s e,
      output translation_entry_s r);
    @(negedge clk);
    acc_valid = 1'b1;
    acc_write = wr;
    acc_addr = ad;
    acc_wdata = e;
    @(negedge clk);
    acc_valid = 1'b0;
    r = acc_rdata;
    chk(64'(acc_ack), 64'h1);
  endtask : acc
  task automatic reg_wr(input logic to_ctl, input logic [63:0] v);
    @(negedge clk);
    cucr_wr = to_ctl;
    tbr_wr = ~to_ctl;
    cucr_wdata = v;
    tbr_wdata = v;
    @(negedge clk);
    cucr_wr = 1'b0;
    tbr_wr = 1'b0;
  endtask : reg_wr
  task automatic fault(input logic am, input logic ij, input logic mis, input logic [63:0] va);
    @(negedge clk);
    fault_valid = 1'b1;
    address_mask_bit = am;
    fault_indirect_jump = ij;
    fault_misaligned = mis;
    fault_va = va;
    fault_status = va[15:0];
    @(negedge clk);
    fault_valid = 1'b0;
  endtask : fault
  task automatic pstore(input logic [63:0] va, input logic exp);
    @(negedge clk);
    ps_valid = 1'b1;
    ps_va = va;
    @(negedge clk);
    ps_valid = 1'b0;
    chk(64'(watch_trap), 64'(exp));
  endtask : pstore

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    {rst_b, di_valid, acc_valid, acc_write, tbr_wr, cucr_wr, fault_valid, ps_valid} = '0;
    {address_mask_bit, fault_indirect_jump, fault_misaligned} = '0;
    {acc_addr, tbr_wdata, cucr_wdata, fault_va, ps_va, fault_status} = '0;
    di_entry = '0;
    acc_wdata = '0;
    watch_va = 64'h0000_0000_0000_8000;
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    chk(cucr_rdata, 64'h0);
    reg_wr(1'b1, '1);
    chk(cucr_rdata, 64'h0000_02ff_0000_0000);
    chk(64'(spec_access_en), 64'h1);
    base = 64'h0000_1234_5670_2000;
    for (int sz = 0; sz < 16; sz += 15) begin
      reg_wr(1'b0, base | 64'hff0 | 64'(sz));
      chk(tbr_rdata, base | 64'(sz));
      u_pipe.lookup(64'h0000_001f_ffff_e000, hit, pa);
      m = (24'h1 << (9 + sz)) - 24'h1;
      chk(table_ptr, base + ({40'h0, m} << 4));
    end
    di_wr(mk(1'b0, 2'h0, 64'h0000_0200_0000_2000, 47'h0abc_def0_2000));
    u_pipe.lookup(64'h0000_0200_0000_2123, hit, pa);
    chk(64'(pa), 64'h0000_0abc_def0_2123);
    di_wr(mk(1'b0, 2'h1, 64'h0000_0400_0002_0000, 47'h1234_5678_ffff));
    u_pipe.lookup(64'h0000_0400_0002_6abc, hit, pa);
    chk(64'(pa), 64'h0000_1234_5678_6abc);
    a = 64'h0000_0100_0000_a000;
    b = 64'h0000_0101_0000_a000;
    c = 64'h0000_0102_0000_a000;
    d = 64'h0000_0103_0000_a000;
    di_wr(mk(1'b0, 2'h0, a, 47'h11_0000_0000));
    di_wr(mk(1'b0, 2'h0, b, 47'h22_0000_0000));
    u_pipe.lookup(a, hit, pa);
    chk(64'(hit), 64'h1);
    di_wr(mk(1'b0, 2'h0, c, 47'h33_0000_0000));
    di_wr(mk(1'b1, 2'h0, d, 47'h44_0000_0000));
    acc(1'b0, 64'h20050, '0, w0);
    acc(1'b0, 64'h20058, '0, w1);
    chk(64'((w0 === mk(1'b0, 2'h0, a, 47'h11_0000_0000) && w1 === mk(1'b0, 2'h0, c,
      47'h33_0000_0000)) || (w1 === mk(1'b0, 2'h0, a, 47'h11_0000_0000) && w0 === mk(1'b0,
      2'h0, c, 47'h33_0000_0000))), 64'h1);
    u_pipe.lookup(b, hit, pa);
    chk(64'(pa), 64'h0000_0022_0000_0000);
    u_pipe.lookup(d, hit, pa);
    chk(64'(pa), 64'h0000_0044_0000_0000);
    acc(1'b1, 64'hffff_ffff_fff6_0038, mk(1'b1, 2'h0, d, 47'h55_0000_0000), w0);
    acc(1'b0, 64'h20038, '0, w0);
    chk_ent(w0, mk(1'b0, 2'h0, d, 47'h55_0000_0000));
    acc(1'b1, 64'h40038, mk(1'b1, 2'h0, c, 47'h66_0000_0000), w0);
    acc(1'b0, 64'h38, '0, w0);
    chk_ent(w0, mk(1'b1, 2'h0, c, 47'h66_0000_0000));
    fault(1'b1, 1'b0, 1'b0, 64'hdead_beef_1234_5678);
    chk(data_fault_address_reg, 64'h0000_0000_1234_5678);
    fault(1'b0, 1'b1, 1'b1, 64'h0bad_0000_0000_0abc);
    chk(data_fault_address_reg, 64'h0000_0000_1234_5678);
    chk(64'(data_fault_status_reg), 64'h5678);
    fault(1'b0, 1'b1, 1'b0, 64'h0bad_0000_0000_0abc);
    chk(data_fault_address_reg, 64'h0bad_0000_0000_0abc);
    reg_wr(1'b1, 64'h0);
    chk(64'(spec_access_en), 64'h0);
    pstore(watch_va, 1'b0);
    reg_wr(1'b1, 64'h0000_0001_0000_0000);
    pstore(watch_va | 64'h5, 1'b1);
    pstore(watch_va | 64'h8, 1'b0);
    test_done();
  end
endmodule : test_xlate_unit
